// [bench/led_phase_shift_and_fault_supervisor_tb.sv]
// self-checking bench for the led phase and fault supervisor
`timescale 1ns/10ps
module led_phase_shift_and_fault_supervisor_tb;
  import led_ctrl_pkg::*;
  localparam int SD    = 4;
  localparam int SSL   = 50;
  localparam int PER   = 255 * SD;
  localparam int LIMIT = 60000;
  logic       core_clk;
  logic       rst;
  logic       scl;
  logic       sda_in;
  logic       sda_out;
  logic       sda_oe;
  logic [7:0] duty;
  sense_s     sense;
  logic [5:0] at_target;
  logic [5:0] above_short;
  logic [5:0] ch_on;
  logic       sw_gate;
  logic [2:0] limit_step;
  logic [1:0] short_sel;
  int         miscompares = 0;
  int         checks = 0;
  int         cyc = 0;
  int         rise_t [6];
  logic [5:0] ch_on_d = 6'h00;
  led_phase_shift_and_fault_supervisor #(.STEP_DIV(SD), .SS_STEP_LEN(SSL))
  uut (.CORE_CLK(core_clk), .RST(rst), .SCL(scl), .SDA_IN(sda_in),
    .SDA_OUT(sda_out), .SDA_OE(sda_oe), .DUTY(duty), .SENSE(sense),
    .CH_AT_TARGET(at_target), .CH_ABOVE_SHORT(above_short),
    .CH_ON(ch_on), .SW_GATE(sw_gate), .LIMIT_STEP(limit_step),
    .SHORT_SEL(short_sel));
  smbus_host_model host (.clk(core_clk), .sda_oe(sda_oe), .scl(scl),
    .sda_in(sda_in));
  initial
  begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic give_verdict;
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : give_verdict
  // channel start times and the hang guard
  always @(posedge core_clk)
  begin
    cyc <= cyc + 1;
    ch_on_d <= ch_on;
    for (int k = 0; k < 6; k++)
      if (ch_on[k] === 1'b1 && ch_on_d[k] === 1'b0)
        rise_t[k] <= cyc;
    if (cyc == LIMIT)
    begin
      miscompares++;
      give_verdict();
    end
  end
  task automatic chk(input string what, input logic [15:0] exp,
                     input logic [15:0] got);
    checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("FAIL %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic cycles(input int n);
    repeat (n) @(negedge core_clk);
  endtask : cycles
  task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] q;
    host.read_reg(a, q);
    chk($sformatf("reg %h", a), {8'h00, exp}, {8'h00, q});
  endtask : rchk
  task automatic new_rise0;
    int t0;
    int n;
    t0 = rise_t[0];
    n = 0;
    while (rise_t[0] == t0 && n < 2 * PER)
    begin
      cycles(1);
      n++;
    end
  endtask : new_rise0
  // ranks follow channel index; last gap is whatever the period leaves
  task automatic phase_chk(input logic [5:0] en, input int gap);
    int r;
    int tl;
    r = 0;
    new_rise0();
    new_rise0();
    cycles(250 * SD);
    for (int k = 0; k < 6; k++)
      if (en[k])
      begin
        chk("phase", 16'(r * gap * SD), 16'(rise_t[k] - rise_t[0]));
        tl = rise_t[k];
        r++;
      end
    new_rise0();
    chk("last gap", 16'((255 - (r - 1) * gap) * SD), 16'(rise_t[0] - tl));
  endtask : phase_chk
  task automatic sw_rise(output int t);
    int n;
    n = 0;
    while (sw_gate !== 1'b0 && n < 400)
    begin
      cycles(1);
      n++;
    end
    while (sw_gate !== 1'b1 && n < 400)
    begin
      cycles(1);
      n++;
    end
    t = cyc;
  endtask : sw_rise
  // the first period after a change may be short, so measure the second
  task automatic sw_chk(input int exp);
    int a;
    int b;
    sw_rise(a);
    sw_rise(a);
    sw_rise(b);
    chk("switch period", 16'(exp), 16'(b - a));
  endtask : sw_chk
  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    int n;
    logic [2:0] prev;
    rst = 1'b1;
    duty = 8'h01;
    sense = '0;
    sense.loop_stable = 1'b1;
    at_target = 6'h00;
    above_short = 6'h00;
    repeat (16) @(negedge core_clk);
    rst = 1'b0;
    cycles(4);
    chk("short sel reset", 16'h0002, 16'(short_sel));
    chk("sda out", 16'h0000, 16'(sda_out));
    rchk(ADDR_CONFIG, CONFIG_RESET);
    rchk(ADDR_MASK, MASK_RESET);
    rchk(ADDR_PHASE, PHASE_RESET);
    host.write_reg(ADDR_FAULT, 8'hff);
    rchk(ADDR_FAULT, 8'h00);
    rchk(8'h30, 8'h00);
    for (int s = 0; s < 3; s++)
    begin
      host.write_reg(ADDR_CONFIG, 8'(s));
      chk("short sel", 16'(s), 16'(short_sel));
    end
    host.write_reg(ADDR_PHASE, 8'h80);
    phase_chk(6'h3f, 255 / 6);
    host.write_reg(ADDR_MASK, 8'h08);
    phase_chk(6'h37, 255 / 5);
    host.write_reg(ADDR_PHASE, 8'h0a);
    phase_chk(6'h37, 10);
    host.write_reg(ADDR_MASK, 8'h00);
    chk("gate before fet", 16'h0000, 16'(sw_gate));
    sense.fet_on = 1'b1;
    prev = 3'h0;
    n = 0;
    while (limit_step !== SS_LAST_STEP && n < 20000)
    begin
      cycles(1);
      n++;
      if (limit_step !== prev)
      begin
        chk("limit step", 16'(prev + 3'h1), 16'(limit_step));
        prev = limit_step;
      end
    end
    chk("ramp span", 16'h0001, 16'(n >= 6 * PER && n >= 7 * SSL));
    sw_chk(SW_LO_CYC);
    host.write_reg(ADDR_CONFIG, 8'h06);
    sw_chk(SW_HI_CYC);
    sense.sw_over_limit = 1'b1;
    cycles(4);
    n = 0;
    for (int i = 0; i < 200; i++)
    begin
      cycles(1);
      n += int'(sw_gate === 1'b1);
    end
    chk("gate over limit", 16'h0000, 16'(n));
    sense.sw_over_limit = 1'b0;
    duty = 8'hff;
    host.write_reg(ADDR_CONFIG, 8'h0a);
    above_short = 6'h04;
    cycles(10);
    chk("short off", 16'h003f, 16'(ch_on));
    sense.loop_stable = 1'b0;
    host.write_reg(ADDR_CONFIG, 8'h02);
    chk("unstable", 16'h003f, 16'(ch_on));
    sense.loop_stable = 1'b1;
    cycles(10);
    chk("short on", 16'h003b, 16'(ch_on));
    above_short = 6'h00;
    rchk(ADDR_FAULT, 8'h01);
    at_target = 6'h1f;
    cycles(10);
    at_target = 6'h1d;
    sense.overvoltage_limit = 1'b1;
    cycles(10);
    sense.overvoltage_limit = 1'b0;
    cycles(5 * PER - 30);
    chk("open wait", 16'h003b, 16'(ch_on));
    cycles(2 * PER + 40);
    chk("open off", 16'h0019, 16'(ch_on));
    rchk(ADDR_MASK, 8'h26);
    rchk(ADDR_FAULT, 8'h09);
    sense.otp_high = 1'b1;
    cycles(4);
    chk("thermal off", 16'h0000, 16'(ch_on));
    chk("thermal gate", 16'h0000, 16'(sw_gate));
    sense.otp_high = 1'b0;
    sense.in_overcurrent = 1'b1;
    cycles(4);
    sense.in_overcurrent = 1'b0;
    cycles(20);
    chk("vout short off", 16'h0000, 16'(ch_on));
    rchk(ADDR_FAULT, 8'h0f);
    chk("bus ack", 16'h0000, 16'(host.nacked));
    give_verdict();
  end
endmodule : led_phase_shift_and_fault_supervisor_tb

// [bench/smbus_host_model.sv]
// management bus host model that drives the register port pins
`timescale 1ns/10ps
module smbus_host_model
#(
  parameter logic [6:0] DEV = 7'h2c
)(
  input  wire logic clk,
  input  wire logic sda_oe,
  output logic      scl,
  output logic      sda_in
);
  logic sda_drv;
  logic nacked;
  // pulled-up line: low while either side pulls it
  assign sda_in = sda_drv & ~sda_oe;
  initial
  begin
    scl = 1'b1;
    sda_drv = 1'b1;
    nacked = 1'b0;
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic hold(input int n);
    repeat (n) @(negedge clk);
  endtask : hold
  // scl phases of 4 core cycles keep above the slave's minimum
  task automatic bit_io(input logic b, output logic r);
    sda_drv = b;
    hold(4);
    scl = 1'b1;
    hold(4);
    r = sda_in;
    scl = 1'b0;
    hold(2);
  endtask : bit_io
  task automatic start;
    sda_drv = 1'b1;
    hold(4);
    scl = 1'b1;
    hold(4);
    sda_drv = 1'b0;
    hold(4);
    scl = 1'b0;
    hold(2);
  endtask : start
  task automatic stop;
    sda_drv = 1'b0;
    hold(4);
    scl = 1'b1;
    hold(4);
    sda_drv = 1'b1;
    hold(4);
  endtask : stop
  // ninth bit released: slave ack on writes, host nack on the read byte
  task automatic byte_io(input logic [7:0] d, input logic rd,
                         output logic [7:0] q);
    logic a;
    for (int i = 7; i >= 0; i--)
      bit_io(d[i], q[i]);
    bit_io(1'b1, a);
    if (!rd && a !== 1'b0)
      nacked = 1'b1;
  endtask : byte_io
  task automatic write_reg(input logic [7:0] ptr, input logic [7:0] d);
    logic [7:0] q;
    start();
    byte_io({DEV, 1'b0}, 1'b0, q);
    byte_io(ptr, 1'b0, q);
    byte_io(d, 1'b0, q);
    stop();
  endtask : write_reg
  task automatic read_reg(input logic [7:0] ptr, output logic [7:0] d);
    logic [7:0] q;
    start();
    byte_io({DEV, 1'b0}, 1'b0, q);
    byte_io(ptr, 1'b0, q);
    start();
    byte_io({DEV, 1'b1}, 1'b0, q);
    byte_io(8'hff, 1'b1, d);
    stop();
  endtask : read_reg
endmodule : smbus_host_model

// [src/led_ctrl_pkg.sv]
// shared constants and types for the led phase and fault supervisor
package led_ctrl_pkg;
  // register addresses on the management bus
  localparam logic [7:0] ADDR_FAULT  = 8'h02;
  localparam logic [7:0] ADDR_CONFIG = 8'h08;
  localparam logic [7:0] ADDR_MASK   = 8'h09;
  localparam logic [7:0] ADDR_PHASE  = 8'h0b;
  // fault/status bit positions
  localparam int FS_CHAN   = 0;
  localparam int FS_THERM  = 1;
  localparam int FS_VSHORT = 2;
  localparam int FS_OVP    = 3;
  // configuration fields
  localparam int CFG_SEL_LSB   = 0;
  localparam int CFG_FREQ_BIT  = 2;
  localparam int CFG_SHORT_OFF = 3;
  localparam int PH_EQUAL_BIT  = 7;
  // short threshold codes: 3.6V, 4.8V, 5.85V
  localparam logic [1:0] SHORT_3V6  = 2'h0;
  localparam logic [1:0] SHORT_4V8  = 2'h1;
  localparam logic [1:0] SHORT_5V85 = 2'h2;
  // reset values
  localparam logic [7:0] CONFIG_RESET = {6'h00, SHORT_5V85};
  localparam logic [7:0] MASK_RESET   = 8'h00;
  localparam logic [7:0] PHASE_RESET  = 8'h00;
  // phase and fault counts
  localparam logic [7:0] PERIOD_STEPS  = 8'hff;
  localparam logic [2:0] OPEN_TIMEOUT  = 3'h6;
  localparam logic [2:0] SS_LAST_STEP  = 3'h7;
  // timing at the core clock
  localparam int CLK_HZ      = 100_000_000;
  localparam int SW_LO_HZ    = 600_000;
  localparam int SW_HI_HZ    = 1_200_000;
  localparam int SW_LO_CYC   = CLK_HZ / SW_LO_HZ;
  localparam int SW_HI_CYC   = CLK_HZ / SW_HI_HZ;
  localparam int SS_TOTAL_NS = 8_000_000;
  localparam int SS_STEP_CYC =
    (SS_TOTAL_NS / 1000 * (CLK_HZ / 1_000_000) + 6) / 7;
  // analog comparator and status inputs
  typedef struct packed {
    logic overvoltage_limit;
    logic otp_low;
    logic otp_high;
    logic in_overcurrent;
    logic fet_on;
    logic loop_stable;
    logic sw_over_limit;
  } sense_s;
  typedef enum logic [2:0] {B_IDLE, B_ADDR, B_PTR, B_WDATA, B_RDATA} bus_e;
  typedef enum logic [1:0] {SS_WAIT, SS_RAMP, SS_RUN} ss_e;
endpackage : led_ctrl_pkg

// [src/led_phase_shift_and_fault_supervisor.sv]
// phase shifted dimming, boost soft-start and led fault supervision
`timescale 1ns/10ps
// What this block does
// - equal select spreads enabled channel starts evenly
// - gap floor(255/N), last gap takes remainder
// - N counted from channels not masked
// - last-to-first gap is period remainder
// - config bit 2 picks 1.2MHz, default 600kHz
// - limit starts 275mA, seven steps to 2.2A
// - ramp spans 8ms, waits for dimming periods
// - no switching until protection fet on
// - over-limit current ends on-time at once
// - channel faults recorded in status 0x02
// - mask 0x09 shows failed, host may preset
// - no channel faults while led loop unstable
// - output short: channels off, cause held
// - short threshold selectable, 5.85V default
// - config bit turns short detection off
// - good channel dropping below target is open
// - ovp or low otp opens non-good channels
// - open channel disabled only after time-out
// - open time-out is six dimming periods
// - string above short threshold fails even if conducting
// - upper otp stops all, sets thermal bit
module led_phase_shift_and_fault_supervisor
  import led_ctrl_pkg::*;
#(
  parameter logic [6:0] DEV_ADDR    = 7'h2c, // arbitrary bus address
  parameter int         STEP_DIV    = 26,
  parameter int         SS_STEP_LEN = SS_STEP_CYC,
  parameter int         NCH         = 6
)(
  input  wire logic           CORE_CLK,
  input  wire logic           RST,
  input  wire logic           SCL,
  input  wire logic           SDA_IN,
  output logic                SDA_OUT,
  output logic                SDA_OE,
  input  wire logic [7:0]     DUTY,
  input  wire sense_s         SENSE,
  input  wire logic [NCH-1:0] CH_AT_TARGET,
  input  wire logic [NCH-1:0] CH_ABOVE_SHORT,
  output logic      [NCH-1:0] CH_ON,
  output logic                SW_GATE,
  output logic      [2:0]     LIMIT_STEP,
  output logic      [1:0]     SHORT_SEL
);
  ////////////////////////////////////////////////////////////////////////
  // input synchronisers
  logic [1:0]     scl_sync, sda_sync;
  logic           scl_d, sda_d;
  sense_s         sn_meta, sn;
  logic [NCH-1:0] tgt_meta, tgt, shrt_meta, shrt;
  always_ff @(posedge CORE_CLK)
  begin
    if (RST)
    begin
      scl_sync <= 2'h3;
      sda_sync <= 2'h3;
      scl_d    <= 1'b1;
      sda_d    <= 1'b1;
      sn_meta  <= '0;
      sn       <= '0;
      tgt_meta <= '0;
      tgt      <= '0;
      shrt_meta <= '0;
      shrt     <= '0;
    end
    else
    begin
      scl_sync <= {scl_sync[0], SCL};
      sda_sync <= {sda_sync[0], SDA_IN};
      scl_d    <= scl_sync[1];
      sda_d    <= sda_sync[1];
      sn_meta  <= SENSE;
      sn       <= sn_meta;
      tgt_meta <= CH_AT_TARGET;
      tgt      <= tgt_meta;
      shrt_meta <= CH_ABOVE_SHORT;
      shrt     <= shrt_meta;
    end
  end
  ////////////////////////////////////////////////////////////////////////
  // management bus slave
  logic       scl_rise, scl_fall, bus_start, bus_stop;
  bus_e       bus_reg;
  logic [3:0] bit_reg;
  logic [7:0] sh_reg, tx_reg, ptr_reg, rd_data;
  logic       ack_reg, nack_reg, rw_reg, wr_en;
  logic [7:0] fault_reg, cfg_reg, mask_reg, phase_reg;
  assign scl_rise  = scl_sync[1] & ~scl_d;
  assign scl_fall  = ~scl_sync[1] & scl_d;
  assign bus_start = scl_sync[1] & scl_d & sda_d & ~sda_sync[1];
  assign bus_stop  = scl_sync[1] & scl_d & ~sda_d & sda_sync[1];
  assign wr_en = scl_fall & (bit_reg == 4'h7) & (bus_reg == B_WDATA);
  assign SDA_OUT = 1'b0;
  always_comb
  begin
    case (ptr_reg)
      ADDR_FAULT:  rd_data = fault_reg;
      ADDR_CONFIG: rd_data = cfg_reg;
      ADDR_MASK:   rd_data = mask_reg;
      ADDR_PHASE:  rd_data = phase_reg;
      default:     rd_data = 8'h00;
    endcase
  end
  always_ff @(posedge CORE_CLK)
  begin
    if (RST | bus_stop)
    begin
      bus_reg <= B_IDLE;
      bit_reg <= 4'h0;
      ack_reg <= 1'b0;
      SDA_OE  <= 1'b0;
    end
    else if (bus_start)
    begin
      bus_reg <= B_ADDR;
      bit_reg <= 4'hf;
      SDA_OE  <= 1'b0;
    end
    // the scl fall that closes a start is not a data bit
    else if (scl_fall && bit_reg == 4'hf)
      bit_reg <= 4'h0;
    else if (scl_rise && bit_reg < 4'h8)
      sh_reg <= {sh_reg[6:0], sda_sync[1]};
    else if (scl_rise && bus_reg == B_RDATA)
      nack_reg <= sda_sync[1];
    else if (scl_fall && bit_reg == 4'h7)
    begin
      bit_reg <= 4'h8;
      case (bus_reg)
        B_ADDR:  ack_reg <= sh_reg[7:1] == DEV_ADDR;
        B_PTR:   ack_reg <= 1'b1;
        B_WDATA: ack_reg <= 1'b1;
        default: ack_reg <= 1'b0;
      endcase
      rw_reg <= sh_reg[0];
      // an idle slave after an address miss must stay off the line
      SDA_OE <= (bus_reg == B_ADDR) ? (sh_reg[7:1] == DEV_ADDR)
                                    : (bus_reg == B_PTR ||
                                       bus_reg == B_WDATA);
    end
    else if (scl_fall && bit_reg == 4'h8)
    begin
      bit_reg <= 4'h0;
      SDA_OE  <= 1'b0;
      case (bus_reg)
        B_ADDR:
          bus_reg <= !ack_reg ? B_IDLE : (rw_reg ? B_RDATA : B_PTR);
        B_PTR:
        begin
          ptr_reg <= sh_reg;
          bus_reg <= B_WDATA;
        end
        B_WDATA: ptr_reg <= ptr_reg + 8'h01;
        B_RDATA:
          if (nack_reg)
            bus_reg <= B_IDLE;
        default: bus_reg <= B_IDLE;
      endcase
      // a read loads the byte at the pointer, then steps on
      if ((bus_reg == B_ADDR && ack_reg && rw_reg) ||
          (bus_reg == B_RDATA && !nack_reg))
      begin
        tx_reg  <= rd_data;
        SDA_OE  <= ~rd_data[7];
        ptr_reg <= ptr_reg + 8'h01;
        nack_reg <= 1'b0;
      end
    end
    else if (scl_fall && bit_reg < 4'h7)
    begin
      bit_reg <= bit_reg + 4'h1;
      if (bus_reg == B_RDATA)
      begin
        tx_reg <= {tx_reg[6:0], 1'b0};
        SDA_OE <= ~tx_reg[6];
      end
    end
  end
  ////////////////////////////////////////////////////////////////////////
  // host registers
  logic [NCH-1:0] fail_set, chan_en;
  logic           shutdown, vshort_reg;
  always_ff @(posedge CORE_CLK)
  begin
    if (RST)
    begin
      cfg_reg   <= CONFIG_RESET;
      phase_reg <= PHASE_RESET;
    end
    else if (wr_en && ptr_reg == ADDR_CONFIG)
      cfg_reg <= sh_reg;
    else if (wr_en && ptr_reg == ADDR_PHASE)
      phase_reg <= sh_reg;
  end
  // hardware failure marks win over a host write in the same cycle
  always_ff @(posedge CORE_CLK)
  begin
    if (RST)
      mask_reg <= MASK_RESET;
    else if (wr_en && ptr_reg == ADDR_MASK)
      mask_reg <= sh_reg | 8'(fail_set);
    else
      mask_reg <= mask_reg | 8'(fail_set);
  end
  // volatile cause register, cleared only by reset
  always_ff @(posedge CORE_CLK)
  begin
    if (RST)
      fault_reg <= 8'h00;
    else
    begin
      if (|fail_set)
        fault_reg[FS_CHAN] <= 1'b1;
      if (sn.otp_high)
        fault_reg[FS_THERM] <= 1'b1;
      if (sn.in_overcurrent)
        fault_reg[FS_VSHORT] <= 1'b1;
      if (sn.overvoltage_limit)
        fault_reg[FS_OVP] <= 1'b1;
    end
  end
  assign SHORT_SEL = cfg_reg[CFG_SEL_LSB +: 2];
  ////////////////////////////////////////////////////////////////////////
  // dimming period: 255 steps from a divider enable
  logic [$clog2(STEP_DIV)-1:0] div_reg;
  logic [7:0]  step_reg, gap;
  logic        step_en, period_end;
  logic [2:0]  n_en;
  assign step_en    = div_reg == ($clog2(STEP_DIV))'(STEP_DIV - 1);
  assign period_end = step_en && step_reg == PERIOD_STEPS - 8'h01;
  always_ff @(posedge CORE_CLK)
  begin
    if (RST || step_en)
      div_reg <= '0;
    else
      div_reg <= div_reg + 1'b1;
  end
  always_ff @(posedge CORE_CLK)
  begin
    if (RST || period_end)
      step_reg <= 8'h00;
    else if (step_en)
      step_reg <= step_reg + 8'h01;
  end
  assign chan_en = ~mask_reg[NCH-1:0];
  always_comb
  begin
    n_en = 3'h0;
    for (int k = 0; k < NCH; k++)
      n_en = n_en + 3'(chan_en[k]);
    case (n_en)
      3'h1:    gap = 8'd255;
      3'h2:    gap = 8'd127;
      3'h3:    gap = 8'd85;
      3'h4:    gap = 8'd63;
      3'h5:    gap = 8'd51;
      3'h6:    gap = 8'd42; // last gap then 255 - 5*42 = 45
      default: gap = 8'd0;
    endcase
    if (!phase_reg[PH_EQUAL_BIT])
      gap = {1'b0, phase_reg[6:0]};
  end
  ////////////////////////////////////////////////////////////////////////
  // per-channel phase and fault supervision
  logic [NCH-1:0] pwm_on, good_reg, open_reg, short_hit, open_fail;
  logic [2:0]     open_cnt [NCH];
  logic           stable;
  assign stable   = sn.loop_stable;
  assign shutdown = sn.otp_high | vshort_reg;
  genvar i;
  generate
    for (i = 0; i < NCH; i++)
    begin : g_ch
      logic [10:0] start_raw;
      logic [7:0]  start, pos;
      logic [2:0]  rank;
      always_comb
      begin
        rank = 3'h0;
        for (int k = 0; k < i; k++)
          rank = rank + 3'(chan_en[k]);
        // wrap keeps the last-to-first gap equal to what is left
        start_raw = 11'(rank) * 11'(gap);
        start = 8'(start_raw % 11'd255);
        pos = (step_reg >= start) ? step_reg - start
                                  : step_reg + PERIOD_STEPS - start;
      end
      assign pwm_on[i] = pos < DUTY;
      assign CH_ON[i]  = pwm_on[i] & chan_en[i] & ~shutdown;
      // a string above the short threshold fails even while it reaches target
      assign short_hit[i] = stable & chan_en[i] & pwm_on[i] & shrt[i] &
                            ~cfg_reg[CFG_SHORT_OFF];
      assign open_fail[i] = stable & open_reg[i] & period_end &
                            open_cnt[i] == OPEN_TIMEOUT - 3'h1;
      assign fail_set[i]  = short_hit[i] | open_fail[i];
      always_ff @(posedge CORE_CLK)
      begin
        if (RST || !chan_en[i])
          good_reg[i] <= 1'b0;
        else if (CH_ON[i] && tgt[i])
          good_reg[i] <= 1'b1;
      end
      always_ff @(posedge CORE_CLK)
      begin
        if (RST || !chan_en[i])
        begin
          open_reg[i] <= 1'b0;
          open_cnt[i] <= 3'h0;
        end
        else
        begin
          if (stable && ((good_reg[i] && CH_ON[i] && !tgt[i]) ||
              ((sn.overvoltage_limit || sn.otp_low) && !good_reg[i])))
            open_reg[i] <= 1'b1;
          // a lasting open must not wrap the count; it parks at the end
          if (open_reg[i] && period_end &&
              open_cnt[i] != OPEN_TIMEOUT - 3'h1)
            open_cnt[i] <= open_cnt[i] + 3'h1;
        end
      end
    end
  endgenerate
  ////////////////////////////////////////////////////////////////////////
  // soft-start of the switch current limit
  ss_e         ss_reg;
  logic [$clog2(SS_STEP_LEN)-1:0] ss_timer;
  logic        seen_period, step_adv, ss_done;
  assign ss_done  = ss_timer == ($clog2(SS_STEP_LEN))'(SS_STEP_LEN - 1);
  assign step_adv = ss_done & seen_period;
  always_ff @(posedge CORE_CLK)
  begin
    if (RST)
      vshort_reg <= 1'b0;
    else if (sn.in_overcurrent)
      vshort_reg <= 1'b1;
  end
  always_ff @(posedge CORE_CLK)
  begin
    if (RST || !sn.fet_on)
    begin
      ss_reg      <= SS_WAIT;
      LIMIT_STEP  <= 3'h0;
      ss_timer    <= '0;
      seen_period <= 1'b0;
    end
    else
    begin
      case (ss_reg)
        SS_WAIT: ss_reg <= SS_RAMP;
        SS_RAMP:
        begin
          // low dimming rates stretch each step to a whole period
          if (period_end)
            seen_period <= 1'b1;
          if (!ss_done)
            ss_timer <= ss_timer + 1'b1;
          if (step_adv)
          begin
            ss_timer    <= '0;
            seen_period <= 1'b0;
            LIMIT_STEP  <= LIMIT_STEP + 3'h1;
            if (LIMIT_STEP == SS_LAST_STEP - 3'h1)
              ss_reg <= SS_RUN;
          end
        end
        SS_RUN:  ss_reg <= SS_RUN;
        default: ss_reg <= SS_WAIT;
      endcase
    end
  end
  ////////////////////////////////////////////////////////////////////////
  // boost switching at 600kHz or 1.2MHz
  logic [7:0] sw_cnt, sw_last;
  logic       on_reg, sw_allow;
  assign sw_last  = cfg_reg[CFG_FREQ_BIT] ? 8'(SW_HI_CYC - 1)
                                          : 8'(SW_LO_CYC - 1);
  assign sw_allow = (ss_reg != SS_WAIT) & ~shutdown;
  always_ff @(posedge CORE_CLK)
  begin
    if (RST || sw_cnt >= sw_last)
      sw_cnt <= 8'h00;
    else
      sw_cnt <= sw_cnt + 8'h01;
  end
  always_ff @(posedge CORE_CLK)
  begin
    if (RST || !sw_allow || sn.sw_over_limit)
      on_reg <= 1'b0;
    else if (sw_cnt == 8'h00)
      on_reg <= 1'b1;
    else if (sw_cnt == {1'b0, sw_last[7:1]})
      on_reg <= 1'b0;
  end
  // the gate drops in the same cycle the limit is seen
  assign SW_GATE = on_reg & ~sn.sw_over_limit & sw_allow;
  ////////////////////////////////////////////////////////////////////////
  // checks
  sequence s_therm;
    sn.otp_high;
  endsequence
  sequence s_off_after;
    (CH_ON == '0) ##1 fault_reg[FS_THERM];
  endsequence
  property p_freq_default;
    @(posedge CORE_CLK) $fell(RST) |-> !cfg_reg[CFG_FREQ_BIT] &&
      SHORT_SEL == SHORT_5V85;
  endproperty
  a_freq_default: assert property (p_freq_default)
    else $error("reset config not 600kHz and 5.85V");
  property p_no_switch_early;
    @(posedge CORE_CLK) disable iff (RST) !sn.fet_on |=> !SW_GATE;
  endproperty
  a_no_switch_early: assert property (p_no_switch_early)
    else $error("switching before fet on");
  property p_limit_cut;
    @(posedge CORE_CLK) disable iff (RST)
      on_reg && sn.sw_over_limit |-> !SW_GATE ##1 !on_reg;
  endproperty
  a_limit_cut: assert property (p_limit_cut)
    else $error("on-time not ended at limit");
  property p_ss_span;
    @(posedge CORE_CLK) disable iff (RST)
      ss_reg == SS_RAMP && step_adv |->
        ss_timer == ($clog2(SS_STEP_LEN))'(SS_STEP_LEN - 1) ##1
        $changed(LIMIT_STEP);
  endproperty
  a_ss_span: assert property (p_ss_span)
    else $error("limit step too early");
  property p_therm;
    @(posedge CORE_CLK) disable iff (RST) s_therm |-> s_off_after;
  endproperty
  a_therm: assert property (p_therm)
    else $error("upper thermal not handled");
  property p_vshort;
    @(posedge CORE_CLK) disable iff (RST)
      sn.in_overcurrent |=> (CH_ON == '0 && fault_reg[FS_VSHORT]) [*4];
  endproperty
  a_vshort: assert property (p_vshort)
    else $error("output short did not stop channels");
  property p_unstable;
    @(posedge CORE_CLK) disable iff (RST) !stable |-> fail_set == '0;
  endproperty
  a_unstable: assert property (p_unstable)
    else $error("fault during unstable loop");
  property p_short_off;
    @(posedge CORE_CLK) disable iff (RST)
      cfg_reg[CFG_SHORT_OFF] |-> short_hit == '0;
  endproperty
  a_short_off: assert property (p_short_off)
    else $error("short seen while disabled");
  property p_report;
    @(posedge CORE_CLK) disable iff (RST)
      fail_set[1] |=> mask_reg[1] && fault_reg[FS_CHAN] && !CH_ON[1];
  endproperty
  a_report: assert property (p_report)
    else $error("failed channel not masked and reported");
  property p_open_time;
    @(posedge CORE_CLK) disable iff (RST)
      open_fail[1] |-> open_cnt[1] == 3'h5 && period_end ##1 !CH_ON[1];
  endproperty
  a_open_time: assert property (p_open_time)
    else $error("open time-out not six periods");
  property p_equal_gap;
    @(posedge CORE_CLK) disable iff (RST)
      phase_reg[PH_EQUAL_BIT] && chan_en == 6'h3f |-> gap == 8'd42;
  endproperty
  a_equal_gap: assert property (p_equal_gap)
    else $error("equal gap wrong for six channels");
endmodule : led_phase_shift_and_fault_supervisor
